// >>> hw/ptp_pulse_gen.sv
/*
  phase accumulator pulse generator: one output step per accumulator carry.
  assumes frequency in pps and a clock of PTP_CLK_HZ.
*/
`include "ptp_defs.svh"
module ptp_pulse_gen
  import ptp_pkg::*;
#(
  parameter int CLK_HZ = `PTP_CLK_HZ
) (
  // clock and reset
  input  wire logic            clk_i,
  input  wire logic            nrst_i,
  // command
  input  wire ptp_gen_cmd_type cmd_i,
  // step out
  output logic                 step_o
);
  typedef struct packed {
    logic [31:0] acc;
    logic        step;
  } gen_state_type;

  gen_state_type s_q, s_d;
  logic [32:0]   sum;

  always_comb begin
    s_d  = s_q;
    sum  = {1'b0, s_q.acc} + {1'b0, cmd_i.freq};
    s_d.step = 1'b0;
    if (!cmd_i.run) begin
      s_d.acc = 32'h0000_0000;
    end else if (sum >= 33'(CLK_HZ / `PTP_EDGES_PER_PULSE)) begin
      // two output edges per pulse, so carry at twice the pulse rate
      s_d.acc  = 32'(sum - 33'(CLK_HZ / `PTP_EDGES_PER_PULSE));
      s_d.step = 1'b1;
    end else begin
      s_d.acc = sum[31:0];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign step_o = s_q.step;
endmodule : ptp_pulse_gen

// >>> hw/ptp_top.sv
/*
  pulse train positioner: four pulse ports, continuous and independent modes,
  trapezoid moves, count preset, error flag, ahb-lite register slave.
  assumes a single 200 MHz clock and one ahb-lite master.
*/
// Overview of operation
// R1 - continuous mode runs until stopped
// R2 - leaving run mode stops all ports
// R3 - continuous: reset or zero speed stops
// R4 - independent stops after preset count
// R5 - software reloads count before each restart
// R6 - start without preset emits nothing
// R7 - absolute preset ignores commanded direction
// R8 - no count change during plain positioning
// R9 - repeated speed command jumps frequency
// R10 - independent stop discards the preset
// R11 - port selector 0 to 3
// R12 - preset stores type and count
// R13 - range check on counts
// R14 - absolute moves count minus position
// R15 - preset while pulsing is an error
// R16 - interrupt command versus cyclic is error
// R17 - out of range operands set error
// R18 - position overwrite keeps computed count
// R19 - trapezoid: start, ramp up, ramp down
// R20 - trapezoid mode nibble decode
// R21 - compensation keeps changed move running
// R22 - ports 0 and 1 share output method
// R23 - ramps step once per 4 ms
// R24 - mode switch while pulsing is error
`include "ptp_defs.svh"
module ptp_top
  import ptp_pkg::*;
#(
  parameter int NPORT      = 4,
  parameter int PERIOD_CYC = `PTP_CTRL_PERIOD_CYC
) (
  // clock and reset
  input  wire logic             CLK_I,
  input  wire logic             NRST_I,
  // ahb-lite slave
  input  wire logic             HSEL_I,
  input  wire logic [31:0]      HADDR_I,
  input  wire logic [1:0]       HTRANS_I,
  input  wire logic             HWRITE_I,
  input  wire logic [2:0]       HSIZE_I,
  input  wire logic [31:0]      HWDATA_I,
  input  wire logic             HREADY_I,
  output logic [31:0]           HRDATA_O,
  output logic                  HREADYOUT_O,
  output logic                  HRESP_O,
  // controller run state
  input  wire logic             RUN_MODE_I,
  // pulse ports
  output logic [NPORT-1:0]      PULSE_O,
  output logic [NPORT-1:0]      DIR_O
);
  typedef struct packed {
    logic [31:0] waddr;
    logic        wpend;
    logic [31:0] rdata;
    logic [3:0]  port;
    logic [15:0] opt;
    logic [31:0] count;
    logic [31:0] freq;
    logic [31:0] startf;
    logic [31:0] accel;
    logic [31:0] decel;
    logic        error_flag;
    logic [31:0] tick;
    logic [NPORT-1:0]      pls;
    ptp_chan_type [NPORT-1:0] ch;
  } top_state_type;

  top_state_type s_q, s_d;
  logic [NPORT-1:0] step;
  ptp_gen_cmd_type [NPORT-1:0] gcmd;
  logic         tick_now;
  logic [3:0]   cmd_code;
  logic [15:0]  p_sel;
  logic         from_irq;
  logic         cont_req;
  logic         dir_req;
  logic [3:0]   nib;
  logic [31:0]  mv;
  logic         err;
  int           pi;

  function automatic logic busy(input ptp_chan_type c);
    busy = (c.mode != PTP_IDLE);
  endfunction : busy

  function automatic logic [31:0] mag(input logic [31:0] v);
    mag = v[31] ? 32'(-v) : v;
  endfunction : mag

  function automatic logic [3:0] busy_vec(input ptp_chan_type [NPORT-1:0] c);
    busy_vec = 4'h0;
    for (int k = 0; k < NPORT; k++) busy_vec[k] = (c[k].mode != PTP_IDLE);
  endfunction : busy_vec

  // independent movement count from preset (absolute minus position)
  function automatic logic [31:0] move_cnt(input logic is_abs, input logic [31:0] n,
                                           input logic [31:0] pos);
    move_cnt = is_abs ? 32'(n - pos) : n; // R14
  endfunction : move_cnt

  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : gen_port
      assign gcmd[g].run  = busy(s_q.ch[g]) && (s_q.ch[g].mode == PTP_CONT || s_q.ch[g].remain != '0);
      assign gcmd[g].dir  = s_q.ch[g].dir;
      assign gcmd[g].freq = s_q.ch[g].freq;
      ptp_pulse_gen u_gen (
        .clk_i  (CLK_I),
        .nrst_i (NRST_I),
        .cmd_i  (gcmd[g]),
        .step_o (step[g])
      );
    end
  endgenerate

  assign tick_now = (s_q.tick == 32'(PERIOD_CYC - 1)); // R23

  always_comb begin
    s_d      = s_q;
    cmd_code = s_q.opt[3:0];
    p_sel    = {12'h000, s_q.port};
    from_irq = s_q.opt[15];
    cont_req = s_q.opt[8];
    dir_req  = s_q.opt[9];
    nib      = s_q.opt[7:4];
    mv       = '0;
    err      = 1'b0;
    pi       = 0;
    s_d.tick = tick_now ? '0 : s_q.tick + 32'h1;

    // per-port pulse stepping and ramps
    for (int i = 0; i < NPORT; i++) begin
      // a stopped port parks its output low and ignores a late step
      s_d.pls[i] = !gcmd[i].run ? 1'b0 : step[i] ? ~s_q.pls[i] : s_q.pls[i];
      if (gcmd[i].run && step[i] && s_q.pls[i]) begin
        s_d.ch[i].pos = s_q.ch[i].dir ? s_q.ch[i].pos - 32'h1 : s_q.ch[i].pos + 32'h1;
        if (s_q.ch[i].mode != PTP_CONT) begin // R1
          s_d.ch[i].remain = s_q.ch[i].remain - 32'h1;
          if (s_q.ch[i].remain == 32'h1) begin
            s_d.ch[i].mode   = PTP_IDLE; // R4
            s_d.ch[i].cyclic = 1'b0;
          end
        end
      end
      if (tick_now && s_q.ch[i].mode == PTP_TRAPZ) begin // R23
        // decelerate when remaining pulses fit the ramp down, else climb while below the target
        if (s_q.ch[i].decel != '0 &&
            s_q.ch[i].remain <= ((s_q.ch[i].freq - s_q.ch[i].start_f) / s_q.ch[i].decel)
                               * (s_q.ch[i].freq / 32'(`PTP_PERIODS_PER_S))) begin // R19
          s_d.ch[i].freq = (s_q.ch[i].freq > s_q.ch[i].start_f + s_q.ch[i].decel)
                           ? s_q.ch[i].freq - s_q.ch[i].decel : s_q.ch[i].start_f;
        end else if (s_q.ch[i].freq < s_q.ch[i].target) begin
          s_d.ch[i].freq = (s_q.ch[i].target - s_q.ch[i].freq > s_q.ch[i].accel)
                           ? s_q.ch[i].freq + s_q.ch[i].accel : s_q.ch[i].target;
        end
      end
    end

    // ahb-lite data phase of a write
    s_d.wpend = 1'b0;
    if (s_q.wpend) begin
      case (s_q.waddr)
        `PTP_REG_PORT:  s_d.port   = HWDATA_I[3:0];
        `PTP_REG_MODE:  s_d.opt    = HWDATA_I[15:0];
        `PTP_REG_COUNT: s_d.count  = HWDATA_I;
        `PTP_REG_FREQ:  s_d.freq   = HWDATA_I;
        `PTP_REG_START: s_d.startf = HWDATA_I;
        `PTP_REG_ACC:   s_d.accel  = HWDATA_I;
        `PTP_REG_DEC:   s_d.decel  = HWDATA_I;
        `PTP_REG_POS: begin
          // overwrite position; computed counts are kept
          if (HWDATA_I[3:0] < 4'(NPORT)) s_d.ch[HWDATA_I[3:0]].pos = s_q.count; // R18
        end
        `PTP_REG_CMD: begin
          cmd_code = HWDATA_I[3:0];
          if (p_sel > `PTP_PORT_MAX || p_sel >= 16'(NPORT)) begin
            err = 1'b1; // R11 R17
          end else begin
            pi = int'(s_q.port);
            if (from_irq && s_q.ch[pi].cyclic && busy(s_q.ch[pi])) err = 1'b1; // R16
            else case (cmd_code)
              `PTP_CMD_PRESET: begin
                if (busy(s_q.ch[pi])) err = 1'b1; // R15
                else if ({s_q.opt[15:14], s_q.opt[13:1]} != '0 &&
                         s_q.opt[15:0] != `PTP_TYPE_REL && s_q.opt[15:0] != `PTP_TYPE_ABS)
                  err = 1'b1; // R17
                else if (!s_q.opt[0] && s_q.count > `PTP_REL_MAX)
                  err = 1'b1; // R13
                else begin
                  // movement count fixed at preset time
                  s_d.ch[pi].remain    = move_cnt(s_q.opt[0], s_q.count, s_q.ch[pi].pos); // R12 R14
                  s_d.ch[pi].preset_ok = 1'b1;
                  // signed compare: target below position means reverse
                  s_d.ch[pi].dir       = s_q.opt[0] ? ($signed(s_q.count) < $signed(s_q.ch[pi].pos)) : 1'b0; // R7
                  s_d.ch[pi].remain    = mag(s_d.ch[pi].remain);
                  s_d.ch[pi].imm_rev   = s_q.opt[0];
                end
              end
              `PTP_CMD_SPEED, `PTP_CMD_RAMP: begin
                if (busy(s_q.ch[pi]) && (cont_req != (s_q.ch[pi].mode == PTP_CONT))) begin
                  err = 1'b1; // R24
                end else if (s_q.freq == '0) begin
                  s_d.ch[pi].mode      = PTP_IDLE; // R3 R10
                  s_d.ch[pi].preset_ok = 1'b0;
                  s_d.ch[pi].cyclic    = 1'b0;
                end else if (cont_req) begin
                  s_d.ch[pi].mode   = PTP_CONT; // R1
                  s_d.ch[pi].freq   = s_q.freq;
                  s_d.ch[pi].dir    = dir_req;
                  s_d.ch[pi].cyclic = ~from_irq;
                end else if (busy(s_q.ch[pi])) begin
                  s_d.ch[pi].freq = s_q.freq; // R9 R8
                end else if (!s_q.ch[pi].preset_ok) begin
                  err = 1'b1; // R6
                end else begin
                  s_d.ch[pi].mode      = PTP_INDEP;
                  s_d.ch[pi].freq      = s_q.freq;
                  s_d.ch[pi].preset_ok = 1'b0; // R5
                  s_d.ch[pi].cyclic    = ~from_irq;
                  if (!s_q.ch[pi].imm_rev) s_d.ch[pi].dir = dir_req; // R7
                end
              end
              `PTP_CMD_TRAP: begin
                if (nib != `PTP_TRAP_D_NC && nib != `PTP_TRAP_D_C &&
                    nib != `PTP_TRAP_I_NC && nib != `PTP_TRAP_I_C) err = 1'b1; // R20
                else if (s_q.count > `PTP_REL_MAX || s_q.accel == '0 || s_q.freq == '0) err = 1'b1; // R17
                else if (busy(s_q.ch[pi]) && s_q.ch[pi].mode != PTP_TRAPZ) err = 1'b1;
                else begin
                  mv = s_q.count;
                  if (busy(s_q.ch[pi]) && !nib[2] && mv < s_q.ch[pi].remain / 32'h2) begin
                    err = 1'b1; // R21
                  end else begin
                    s_d.ch[pi].mode    = PTP_TRAPZ; // R19
                    s_d.ch[pi].remain  = mv;
                    s_d.ch[pi].target  = s_q.freq;
                    s_d.ch[pi].start_f = s_q.startf;
                    s_d.ch[pi].accel   = s_q.accel;
                    s_d.ch[pi].decel   = s_q.decel;
                    s_d.ch[pi].comp    = nib[2]; // R20
                    s_d.ch[pi].imm_rev = nib[3];
                    s_d.ch[pi].dir     = dir_req;
                    s_d.ch[pi].cyclic  = ~from_irq;
                    if (!busy(s_q.ch[pi])) s_d.ch[pi].freq = s_q.startf;
                  end
                end
              end
              `PTP_CMD_RESET: begin
                s_d.ch[pi].mode      = PTP_IDLE; // R3 R10
                s_d.ch[pi].preset_ok = 1'b0;
                s_d.ch[pi].cyclic    = 1'b0;
              end
              default: err = 1'b1;
            endcase
          end
          s_d.error_flag = err; // R17
        end
        default: ;
      endcase
    end

    // address phase capture and read data
    if (HSEL_I && HREADY_I && HTRANS_I[1]) begin
      s_d.wpend = HWRITE_I;
      s_d.waddr = HADDR_I;
      case (HADDR_I)
        `PTP_REG_PORT:   s_d.rdata = {28'h0, s_q.port};
        `PTP_REG_MODE:   s_d.rdata = {16'h0, s_q.opt};
        `PTP_REG_COUNT:  s_d.rdata = s_q.count;
        `PTP_REG_FREQ:   s_d.rdata = s_q.freq;
        `PTP_REG_START:  s_d.rdata = s_q.startf;
        `PTP_REG_ACC:    s_d.rdata = s_q.accel;
        `PTP_REG_DEC:    s_d.rdata = s_q.decel;
        `PTP_REG_STATUS: s_d.rdata = {23'h0, s_q.error_flag, 4'h0, busy_vec(s_q.ch)};
        `PTP_REG_POS:    s_d.rdata = s_q.ch[s_q.port[1:0]].pos;
        default:         s_d.rdata = 32'h0000_0000;
      endcase
    end

    // run-mode stop comes last, so no command in the same cycle restarts a port
    for (int i = 0; i < NPORT; i++) begin
      if (!RUN_MODE_I) begin
        s_d.ch[i].mode      = PTP_IDLE; // R2
        s_d.ch[i].cyclic    = 1'b0;
        s_d.ch[i].preset_ok = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign HRDATA_O    = s_q.rdata;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;
  assign PULSE_O     = s_q.pls;
  for (g = 0; g < NPORT; g++) begin : gen_dir
    assign DIR_O[g] = s_q.ch[g].dir;
  end

  stop_runmode_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    !RUN_MODE_I |=> busy_vec(s_q.ch) == 4'h0) else $error("ports busy after leaving run mode"); // R2
  flag_clear_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (s_q.wpend && s_q.waddr == `PTP_REG_CMD && HWDATA_I[3:0] == `PTP_CMD_RESET && s_q.port < 4'(NPORT)
     && !(s_q.opt[15] && s_q.ch[s_q.port[1:0]].cyclic))
    |=> !s_q.error_flag && !s_q.ch[$past(s_q.port[1:0])].preset_ok) else $error("reset left flag or preset"); // R10
  port_range_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (s_q.wpend && s_q.waddr == `PTP_REG_CMD && s_q.port >= 4'(NPORT)) |=> s_q.error_flag)
    else $error("bad port not flagged"); // R11
  count_stop_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (s_q.ch[0].mode == PTP_INDEP && s_q.ch[0].remain == 32'h1 && step[0] && s_q.pls[0] && RUN_MODE_I)
    |=> s_q.ch[0].mode == PTP_IDLE) else $error("independent move overran"); // R4
  preset_busy_a: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R15
    (s_q.wpend && s_q.waddr == `PTP_REG_CMD && HWDATA_I[3:0] == `PTP_CMD_PRESET && s_q.port < 4'(NPORT)
     && busy(s_q.ch[s_q.port[1:0]])) |=> s_q.error_flag)
    else $error("preset accepted while pulsing");
  mode_switch_a: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R24
    (s_q.wpend && s_q.waddr == `PTP_REG_CMD && HWDATA_I[3:0] == `PTP_CMD_SPEED && s_q.port < 4'(NPORT)
     && s_q.ch[s_q.port[1:0]].mode == PTP_CONT && !s_q.opt[8]) |=> s_q.error_flag)
    else $error("mode switch accepted while pulsing");
  cont_zero_a: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R3
    (s_q.wpend && s_q.waddr == `PTP_REG_CMD && HWDATA_I[3:0] == `PTP_CMD_SPEED && s_q.port < 4'(NPORT)
     && s_q.ch[s_q.port[1:0]].mode == PTP_CONT && s_q.opt[8] && !s_q.opt[15] && s_q.freq == 32'h0000_0000)
    |=> !busy(s_q.ch[$past(s_q.port[1:0])])) else $error("zero speed did not stop");
  no_preset_a: assert property (@(posedge CLK_I) disable iff (!NRST_I) // R6
    (s_q.wpend && s_q.waddr == `PTP_REG_CMD && HWDATA_I[3:0] == `PTP_CMD_SPEED && s_q.port < 4'(NPORT)
     && !busy(s_q.ch[s_q.port[1:0]]) && !s_q.ch[s_q.port[1:0]].preset_ok && !s_q.opt[8]
     && s_q.freq != 32'h0000_0000)
    |=> s_q.error_flag && !busy(s_q.ch[$past(s_q.port[1:0])])) else $error("start without preset ran");
endmodule : ptp_top

// >>> include/ptp_defs.svh
/*
  constants of the pulse train positioner: register offsets, command codes,
  operand encodings, ranges and timing.
  assumes inclusion by bare name from package and design files.
*/
`ifndef PTP_DEFS_SVH
`define PTP_DEFS_SVH
`define PTP_CLK_HZ         200000000
`define PTP_CTRL_PERIOD_MS 4
`define PTP_CTRL_PERIOD_CYC ((`PTP_CLK_HZ / 1000) * `PTP_CTRL_PERIOD_MS)
`define PTP_REG_CMD        32'h0000_0000
`define PTP_REG_PORT       32'h0000_0004
`define PTP_REG_MODE       32'h0000_0008
`define PTP_REG_COUNT      32'h0000_000c
`define PTP_REG_FREQ       32'h0000_0010
`define PTP_REG_START      32'h0000_0014
`define PTP_REG_ACC        32'h0000_0018
`define PTP_REG_DEC        32'h0000_001c
`define PTP_REG_STATUS     32'h0000_0020
`define PTP_REG_POS        32'h0000_0024
`define PTP_CMD_SPEED      4'h1
`define PTP_CMD_PRESET     4'h2
`define PTP_CMD_TRAP       4'h3
`define PTP_CMD_RAMP       4'h4
`define PTP_CMD_RESET      4'h5
`define PTP_PORT_MAX       16'h0003
`define PTP_TYPE_REL       16'h0000
`define PTP_TYPE_ABS       16'h0001
`define PTP_REL_MAX        32'h7fff_ffff
`define PTP_TRAP_D_NC      4'h0
`define PTP_TRAP_D_C       4'h4
`define PTP_TRAP_I_NC      4'h8
`define PTP_TRAP_I_C       4'hc
`define PTP_ACC_BIT        32
`define PTP_FRAC_W         32
`define PTP_EDGES_PER_PULSE 2
`define PTP_PERIODS_PER_S  (1000 / `PTP_CTRL_PERIOD_MS)
`endif

// >>> include/ptp_pkg.sv
/*
  types of the pulse train positioner.
  assumes ptp_defs.svh on the include path.
*/
`include "ptp_defs.svh"
package ptp_pkg;
  typedef enum logic [1:0] {
    PTP_IDLE  = 2'b00,
    PTP_CONT  = 2'b01,
    PTP_INDEP = 2'b10,
    PTP_TRAPZ = 2'b11
  } ptp_run_type;

  typedef struct packed {
    logic        run;
    logic        dir;
    logic [31:0] freq;
  } ptp_gen_cmd_type;

  typedef struct packed {
    ptp_run_type mode;
    logic        dir;
    logic        preset_ok;
    logic [31:0] remain;
    logic [31:0] freq;
    logic [31:0] target;
    logic [31:0] start_f;
    logic [31:0] accel;
    logic [31:0] decel;
    logic        comp;
    logic        imm_rev;
    logic        cyclic;
    logic [31:0] pos;
  } ptp_chan_type;
endpackage : ptp_pkg

// >>> test/ptp_drive_model.sv
/*
  motor driver model: counts steps and keeps the last direction of each port.
  assumes step and direction levels change on the rising clock edge.
*/
module ptp_drive_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // pulse ports
  input  wire logic [3:0]  step_i,
  input  wire logic [3:0]  dir_i,
  // observation
  input  wire logic        clr_i,
  output logic [31:0]      cnt_o [4],
  output logic [3:0]       dir_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] step_q;

  // one output method on every port: step plus direction level
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      step_q <= 4'h0;
      dir_o  <= 4'h0;
      for (int i = 0; i < 4; i++) cnt_o[i] <= 32'h0;
    end else begin
      step_q <= step_i;
      for (int i = 0; i < 4; i++) begin
        if (clr_i) begin
          cnt_o[i] <= 32'h0;
        end else if (step_i[i] && !step_q[i]) begin
          cnt_o[i] <= cnt_o[i] + 32'h1;
          dir_o[i] <= dir_i[i];
        end
      end
    end
  end
endmodule : ptp_drive_model

// >>> test/pulse_train_positioner_tb.sv
/*
  bench of the pulse train positioner: ahb-lite master tasks, one task per scenario.
  assumes ptp_top with a short ramp period and the drive model on the pulse ports.
*/
`include "ptp_defs.svh"
module pulse_train_positioner_tb
  import ptp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] F1 = 32'h000f_4240;
  localparam logic [31:0] CONT = 32'h0000_0100;
  logic        clk, nrst, hsel, hwrite, hready, hresp, run_mode, clr;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  pulse, dir, mdir;
  logic [31:0] cnt [4];
  int          n_fail = 0;
  int          tests_run = 0;
  int          cyc = 0;

  ptp_top #(.NPORT(4), .PERIOD_CYC(100)) ptp_top_inst (
    .CLK_I(clk), .NRST_I(nrst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .RUN_MODE_I(run_mode),
    .PULSE_O(pulse), .DIR_O(dir));
  ptp_drive_model ptp_drive_model_inst (
    .clk_i(clk), .nrst_i(nrst), .step_i(pulse), .dir_i(dir), .clr_i(clr), .cnt_o(cnt),
    .dir_o(mdir));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic stuck(input string nm);
    n_fail++;
    $display("[ERR] %s expected done seen timeout", nm);
    end_sim();
  endtask : stuck

  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 20);
    if (hready !== 1'b1) stuck("hready");
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask : rd

  task automatic cmd(input logic [31:0] p, m, n, f, input logic [3:0] c);
    wr(`PTP_REG_PORT, p);
    wr(`PTP_REG_MODE, m);
    wr(`PTP_REG_COUNT, n);
    wr(`PTP_REG_FREQ, f);
    wr(`PTP_REG_CMD, {28'h0, c});
  endtask : cmd

  task automatic status(output logic [31:0] s);
    rd(`PTP_REG_STATUS, s);
  endtask : status

  task automatic err(input logic e);
    logic [31:0] s;
    status(s);
    chk("error_flag", {31'h0, e}, {31'h0, s[8]});
  endtask : err

  task automatic wait_idle(input int p, output int t);
    logic [31:0] s;
    int t0;
    t0 = cyc;
    do status(s); while (s[p] !== 1'b0 && cyc - t0 < 20000);
    t = cyc - t0;
    if (s[p] !== 1'b0) stuck("busy");
  endtask : wait_idle

  task automatic clr_cnt();
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    @(posedge clk);
  endtask : clr_cnt

  // stopped port: not busy now and no further steps
  task automatic quiet(input int p);
    logic [31:0] s, c;
    status(s);
    c = cnt[p];
    chk("busy", 32'h0, {31'h0, s[p]});
    repeat (600) @(posedge clk);
    chk("steps_after_stop", c, cnt[p]);
  endtask : quiet

  task automatic t_indep();
    int t;
    clr_cnt();
    cmd(0, 0, 32'h28, 0, `PTP_CMD_PRESET);
    err(1'b0);
    cmd(0, 0, 0, F1, `PTP_CMD_SPEED);
    repeat (2000) @(posedge clk);
    cmd(0, 0, 0, 32'h001e_8480, `PTP_CMD_SPEED);
    wait_idle(0, t);
    chk("count0", 32'h28, cnt[0]);
    chk("faster", 32'h1, t < 4500);
    $display("test indep done");
  endtask : t_indep

  task automatic t_stop_indep();
    logic [3:0] code [2] = '{`PTP_CMD_SPEED, `PTP_CMD_RESET};
    clr_cnt();
    cmd(0, 0, 0, F1, `PTP_CMD_SPEED);
    err(1'b1);
    repeat (600) @(posedge clk);
    chk("no_preset_steps", 32'h0, cnt[0]);
    for (int i = 0; i < 2; i++) begin
      cmd(0, 0, 32'h3e8, 0, `PTP_CMD_PRESET);
      cmd(0, 0, 0, F1, `PTP_CMD_SPEED);
      repeat (1000) @(posedge clk);
      cmd(0, 0, 0, 0, code[i]);
      quiet(0);
      clr_cnt();
      cmd(0, 0, 0, F1, `PTP_CMD_SPEED);
      err(1'b1);
      repeat (600) @(posedge clk);
      chk("restart_steps", 32'h0, cnt[0]);
    end
    $display("test stop indep done");
  endtask : t_stop_indep

  task automatic t_abs();
    logic [31:0] s;
    int t;
    clr_cnt();
    cmd(1, 32'h1, 32'h5, 0, `PTP_CMD_PRESET);
    cmd(1, 32'h200, 0, F1, `PTP_CMD_SPEED);
    wait_idle(1, t);
    chk("abs_fwd", 32'h5, cnt[1]);
    chk("abs_dir", 32'h0, {31'h0, mdir[1]});
    cmd(1, 32'h1, 32'h2, 0, `PTP_CMD_PRESET);
    cmd(1, 0, 0, F1, `PTP_CMD_SPEED);
    wait_idle(1, t);
    chk("abs_back", 32'h8, cnt[1]);
    chk("abs_rev", 32'h1, {31'h0, mdir[1]});
    rd(`PTP_REG_POS, s);
    chk("pos1", 32'h2, s);
    cmd(2, 32'h1, 32'h6, 0, `PTP_CMD_PRESET);
    wr(`PTP_REG_COUNT, 32'h64);
    wr(`PTP_REG_POS, 32'h2);
    cmd(2, 0, 0, F1, `PTP_CMD_SPEED);
    wait_idle(2, t);
    chk("kept_count", 32'h6, cnt[2]);
    $display("test abs done");
  endtask : t_abs

  task automatic t_trap();
    int t;
    clr_cnt();
    wr(`PTP_REG_START, 32'h0007_a120);
    wr(`PTP_REG_ACC, 32'h0001_86a0);
    wr(`PTP_REG_DEC, 32'h0001_86a0);
    for (int i = 0; i < 4; i++) begin
      cmd(3, i << 6, 32'h8, F1, `PTP_CMD_TRAP);
      err(1'b0);
      wait_idle(3, t);
      chk("trap_count", 32'h8 * (i + 1), cnt[3]);
    end
    $display("test trap done");
  endtask : t_trap

  task automatic t_cont();
    logic [3:0] code [3] = '{`PTP_CMD_SPEED, `PTP_CMD_RAMP, `PTP_CMD_RESET};
    logic [31:0] c;
    for (int i = 0; i < 3; i++) begin
      clr_cnt();
      cmd(1, CONT, 0, F1, `PTP_CMD_SPEED);
      repeat (4000) @(posedge clk);
      c = cnt[1];
      chk("cont_rate", 32'h1, c >= 32'h12 && c <= 32'h15);
      cmd(1, 0, 32'h5, 0, `PTP_CMD_PRESET);
      err(1'b1);
      cmd(1, 0, 0, F1, `PTP_CMD_SPEED);
      err(1'b1);
      cmd(1, CONT | 32'h8000, 0, F1, `PTP_CMD_SPEED);
      err(1'b1);
      cmd(1, CONT, 0, F1, `PTP_CMD_SPEED);
      err(1'b0);
      cmd(1, CONT, 0, 0, code[i]);
      quiet(1);
    end
    cmd(2, CONT, 0, F1, `PTP_CMD_SPEED);
    cmd(3, CONT, 0, F1, `PTP_CMD_SPEED);
    run_mode <= 1'b0;
    @(posedge clk);
    quiet(2);
    quiet(3);
    run_mode <= 1'b1;
    $display("test cont done");
  endtask : t_cont

  task automatic t_range();
    logic [31:0] s;
    cmd(4, 0, 0, 0, `PTP_CMD_PRESET);
    err(1'b1);
    cmd(0, 0, 32'h8000_0000, 0, `PTP_CMD_PRESET);
    err(1'b1);
    cmd(3, 0, 32'h7fff_ffff, 0, `PTP_CMD_PRESET);
    err(1'b0);
    cmd(0, 32'h1, 32'h8000_0000, 0, `PTP_CMD_PRESET);
    err(1'b0);
    rd(32'h0000_0040, s);
    chk("unmapped", 32'h0, s);
    chk("hresp_okay", 32'h0, {31'h0, hresp});
    $display("test range done");
  endtask : t_range

  initial begin
    nrst     = 1'b0;
    hsel     = 1'b0;
    haddr    = 32'h0;
    htrans   = 2'h0;
    hwrite   = 1'b0;
    hsize    = 3'h2;
    hwdata   = 32'h0;
    run_mode = 1'b1;
    clr      = 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_indep();
    t_stop_indep();
    t_abs();
    t_trap();
    t_cont();
    t_range();
    end_sim();
  end
endmodule : pulse_train_positioner_tb
